//--- jtp_tap_pin_ctrl.v
// Scan test access port: pin sampling, TAP machine, shift paths, debug modes
`timescale 1ns/1ps
`include "jtp_defs.vh"

// Function
// - Test reset high gives scan system control
// - Test reset low: functional mode, ignore scan
// - Mode select sampled on rising test clock
// - Data in captured on rising test clock
// - Data out shifted on falling test clock
// - Pins 1/0 plus reset rise: boundary-scan
// - Pins 0/1 at reset end: debug hold
module jtp_tap_pin_ctrl (
  input wire core_clk_in,
  input wire rst_in,
  input wire tck_in,
  input wire tms_in,
  input wire tdi_in,
  input wire trst_in,
  input wire first_debug_pin_in,
  input wire second_debug_pin_in,
  input wire [`JTP_DR_W-1:0] dr_capture_in,
  output reg tdo_out,
  output reg tdo_oe_n_out,
  output reg scan_control_out,
  output reg boundary_scan_out,
  output reg boot_suspend_debug_hold_out,
  output reg [3:0] tap_state_out,
  output reg [`JTP_IR_W-1:0] ir_out,
  output reg [`JTP_DR_W-1:0] dr_update_out,
  output reg dr_update_stb_out
);

  // Synchroniser stages; first stage read only by the second
  // Bit 4 first debug pin, 3 test reset, 2 data in, 1 mode select, 0 test clock
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  // Second debug pin has its own pair of stages
  reg second_sync1_ff; // First stage
  reg second_sync_ff; // Second stage, the only one read by logic
  // Previous sampled clock and reset for edge finding
  // Both reset low, the idle level of their pins, so no false edge follows reset
  reg tck_prev_ff;
  reg trst_prev_ff;
  // Internal shift registers
  reg [`JTP_IR_W-1:0] ir_sh_ff; // Instruction shift stage
  reg [`JTP_DR_W-1:0] dr_sh_ff; // Data shift stage; bit 0 doubles as the bypass bit
  // Next TAP state, decoded from the current state and mode select
  reg [3:0] nxt_state;

  // Synchronised copies of the probe pins
  wire tck_s = sync2_ff[0]; // Test clock
  wire tms_s = sync2_ff[1]; // Mode select
  wire tdi_s = sync2_ff[2]; // Data in
  wire trst_s = sync2_ff[3]; // Test reset
  wire dbg1_s = sync2_ff[4]; // First debug pin
  wire dbg2_s = second_sync_ff; // Second debug pin
  // Edges of the sampled test clock and test reset
  // A test clock edge is found one core clock after it leaves the synchroniser
  wire tck_rise = tck_s & ~tck_prev_ff;
  wire tck_fall = ~tck_s & tck_prev_ff;
  wire trst_rise = trst_s & ~trst_prev_ff;
  wire trst_fall = ~trst_s & trst_prev_ff;
  // Bypass instruction selected: one-bit data path
  wire bypass_sel = (ir_out == `JTP_IR_BYPASS);
  // Scan logic is live only while test reset is high
  // Test reset low means functional mode; every scan pin is then ignored
  wire scan_en = trst_s;

  // Two-flop synchronisers for every pin from the probe
  // Latency is two core clocks, plus one for edge finding; the probe must
  // hold each test clock level for more than three core clocks
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= 5'h0_0;
      sync2_ff <= 5'h0_0;
      second_sync1_ff <= 1'b0;
      second_sync_ff <= 1'b0;
      tck_prev_ff <= 1'b0;
      trst_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {first_debug_pin_in, trst_in, tdi_in, tms_in, tck_in};
      sync2_ff <= sync1_ff;
      second_sync1_ff <= second_debug_pin_in;
      second_sync_ff <= second_sync1_ff;
      tck_prev_ff <= tck_s;
      trst_prev_ff <= trst_s;
    end
  end

  // TAP next state from mode select
  // Pure decode; the state only takes this value where a test clock rise is seen,
  // so mode select needs no further qualifying here
  // Unused codes cannot occur, but fall back to reset if they do
  // Mode select is read from the same synchroniser as the test clock
  always @* begin
    case (tap_state_out)
      `JTP_ST_RESET: nxt_state = tms_s ? `JTP_ST_RESET : `JTP_ST_IDLE;
      `JTP_ST_IDLE: nxt_state = tms_s ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
      `JTP_ST_SEL_DR: nxt_state = tms_s ? `JTP_ST_SEL_IR : `JTP_ST_CAP_DR;
      `JTP_ST_CAP_DR: nxt_state = tms_s ? `JTP_ST_EX1_DR : `JTP_ST_SH_DR;
      `JTP_ST_SH_DR: nxt_state = tms_s ? `JTP_ST_EX1_DR : `JTP_ST_SH_DR;
      `JTP_ST_EX1_DR: nxt_state = tms_s ? `JTP_ST_UPD_DR : `JTP_ST_PAU_DR;
      `JTP_ST_PAU_DR: nxt_state = tms_s ? `JTP_ST_EX2_DR : `JTP_ST_PAU_DR;
      `JTP_ST_EX2_DR: nxt_state = tms_s ? `JTP_ST_UPD_DR : `JTP_ST_SH_DR;
      `JTP_ST_UPD_DR: nxt_state = tms_s ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
      `JTP_ST_SEL_IR: nxt_state = tms_s ? `JTP_ST_RESET : `JTP_ST_CAP_IR;
      `JTP_ST_CAP_IR: nxt_state = tms_s ? `JTP_ST_EX1_IR : `JTP_ST_SH_IR;
      `JTP_ST_SH_IR: nxt_state = tms_s ? `JTP_ST_EX1_IR : `JTP_ST_SH_IR;
      `JTP_ST_EX1_IR: nxt_state = tms_s ? `JTP_ST_UPD_IR : `JTP_ST_PAU_IR;
      `JTP_ST_PAU_IR: nxt_state = tms_s ? `JTP_ST_EX2_IR : `JTP_ST_PAU_IR;
      `JTP_ST_EX2_IR: nxt_state = tms_s ? `JTP_ST_UPD_IR : `JTP_ST_SH_IR;
      `JTP_ST_UPD_IR: nxt_state = tms_s ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
      default: nxt_state = `JTP_ST_RESET;
    endcase
  end

  // Rising test clock: state step, capture and shift in
  // Update happens on the rise that leaves an update state; this is half a
  // test clock later than a falling-edge update, traded for a single
  // edge detector path
  // Low test reset holds the machine in its reset state on every core clock
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tap_state_out <= `JTP_ST_RESET;
      ir_sh_ff <= 4'h0;
      dr_sh_ff <= 32'h0000_0000;
      ir_out <= `JTP_IR_RESET;
      dr_update_out <= 32'h0000_0000;
      dr_update_stb_out <= 1'b0;
    end else begin
      dr_update_stb_out <= 1'b0;
      if (!scan_en) begin
        // Scan held in reset while test reset is low
        tap_state_out <= `JTP_ST_RESET;
        ir_out <= `JTP_IR_RESET;
      end else if (tck_rise) begin
        tap_state_out <= nxt_state;
        case (tap_state_out)
          // Leaving reset reloads the bypass instruction
          `JTP_ST_RESET: ir_out <= `JTP_IR_RESET;
          `JTP_ST_CAP_IR: ir_sh_ff <= `JTP_IR_CAPTURE;
          `JTP_ST_SH_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[`JTP_IR_W-1:1]};
          // New instruction takes effect here
          `JTP_ST_UPD_IR: ir_out <= ir_sh_ff;
          `JTP_ST_CAP_DR: begin
            // Bypass captures zero so the probe can count its chain length
            if (bypass_sel) begin
              dr_sh_ff <= 32'h0000_0000;
            end else begin
              // Any other instruction loads the word offered at the port
              dr_sh_ff <= dr_capture_in;
            end
          end
          `JTP_ST_SH_DR: begin
            // Bypass uses one bit; others the full word
            if (bypass_sel) begin
              dr_sh_ff <= {31'h0000_0000, tdi_s};
            end else begin
              dr_sh_ff <= {tdi_s, dr_sh_ff[`JTP_DR_W-1:1]};
            end
          end
          // Hand the shifted word on with a one-cycle strobe
          `JTP_ST_UPD_DR: begin
            dr_update_out <= dr_sh_ff;
            dr_update_stb_out <= 1'b1;
          end
          // Other states leave both shift stages alone
          default: ir_sh_ff <= ir_sh_ff;
        endcase
      end
    end
  end

  // Falling test clock: drive data out only in shift states
  // Data out is launched three core clocks after the test clock falls,
  // which leaves the probe the low phase less those clocks of setup margin
  // The enable is active low and goes inactive outside shift states
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tdo_out <= 1'b0;
      tdo_oe_n_out <= 1'b1;
    end else if (!scan_en) begin
      // Line released while the scan system is idle
      tdo_oe_n_out <= 1'b1;
    end else if (tck_fall) begin
      // Shift states own the line; all others release it
      if (tap_state_out == `JTP_ST_SH_IR) begin
        tdo_out <= ir_sh_ff[0];
        tdo_oe_n_out <= 1'b0;
      end else if (tap_state_out == `JTP_ST_SH_DR) begin
        tdo_out <= dr_sh_ff[0];
        tdo_oe_n_out <= 1'b0;
      end else begin
        tdo_oe_n_out <= 1'b1;
      end
    end
  end

  // Mode latches: scan control, boundary-scan, debug hold
  // Debug pins pass the same synchroniser depth as test reset,
  // so a pin that settles before the reset edge is seen in time
  // Boundary-scan ends at a test reset fall; debug hold is re-judged there
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scan_control_out <= 1'b0;
      boundary_scan_out <= 1'b0;
      boot_suspend_debug_hold_out <= 1'b0;
    end else begin
      // Scan control follows test reset with the synchroniser delay plus one register clock
      scan_control_out <= scan_en;
      // Boundary-scan latches on a test reset rise with pins high, low
      if (trst_rise && dbg1_s && !dbg2_s) begin
        boundary_scan_out <= 1'b1;
      end else if (trst_fall) begin
        boundary_scan_out <= 1'b0;
      end
      // Pins checked at test reset release
      if (trst_fall) begin
        boot_suspend_debug_hold_out <= !dbg1_s && dbg2_s;
      end
    end
  end

endmodule // jtp_tap_pin_ctrl

//--- jtp_defs.vh
// Constants for the scan test access port pin control block
`ifndef JTP_DEFS_VH
`define JTP_DEFS_VH
// TAP states, 4-bit binary codes
`define JTP_ST_RESET 4'h0
`define JTP_ST_IDLE 4'h1
`define JTP_ST_SEL_DR 4'h2
`define JTP_ST_CAP_DR 4'h3
`define JTP_ST_SH_DR 4'h4
`define JTP_ST_EX1_DR 4'h5
`define JTP_ST_PAU_DR 4'h6
`define JTP_ST_EX2_DR 4'h7
`define JTP_ST_UPD_DR 4'h8
`define JTP_ST_SEL_IR 4'h9
`define JTP_ST_CAP_IR 4'hA
`define JTP_ST_SH_IR 4'hB
`define JTP_ST_EX1_IR 4'hC
`define JTP_ST_PAU_IR 4'hD
`define JTP_ST_EX2_IR 4'hE
`define JTP_ST_UPD_IR 4'hF
// Register widths
`define JTP_IR_W 4
`define JTP_DR_W 32
// Instruction values: capture, reset and bypass
`define JTP_IR_CAPTURE 4'h1
`define JTP_IR_RESET 4'hF
`define JTP_IR_BYPASS 4'hF
`endif

//--- jtp_tap_pin_ctrl_assertions.sv
// Checker bound to the test port pin control block
`timescale 1ns/1ps
`include "jtp_defs.vh"
module jtp_chk (
  input wire core_clk_in,
  input wire rst_in,
  input wire tck_in,
  input wire trst_in,
  input wire first_debug_pin_in,
  input wire second_debug_pin_in,
  input wire tdo_out,
  input wire tdo_oe_n_out,
  input wire scan_control_out,
  input wire boundary_scan_out,
  input wire boot_suspend_debug_hold_out,
  input wire [3:0] tap_state_out,
  input wire dr_update_stb_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Pins held long enough to pass the synchronisers
  sequence bscan_entry;
    first_debug_pin_in && !second_debug_pin_in && $rose(trst_in) ##1
      (first_debug_pin_in && !second_debug_pin_in && trst_in) [*3];
  endsequence
  sequence hold_entry;
    !first_debug_pin_in && second_debug_pin_in && $fell(trst_in) ##1
      (!first_debug_pin_in && second_debug_pin_in && !trst_in) [*3];
  endsequence
  chk_scan_follow: assert property (trst_in [*6] |-> scan_control_out)
    else $error("scan control missing");
  chk_func_mode: assert property (!trst_in [*6] |-> !scan_control_out &&
    tap_state_out == `JTP_ST_RESET && tdo_oe_n_out) else $error("not functional");
  chk_state_tck: assert property ((!tck_in && trst_in) [*4] |=>
    $stable(tap_state_out)) else $error("state moved without tck");
  chk_tdo_fall: assert property ((tck_in && trst_in) [*4] |=> $stable(tdo_out))
    else $error("tdo moved while tck high");
  chk_bscan_set: assert property (bscan_entry |-> ##[0:4] boundary_scan_out)
    else $error("boundary scan not set");
  chk_hold_set: assert property (hold_entry |-> ##[0:4] boot_suspend_debug_hold_out)
    else $error("debug hold not set");
  chk_strobe_pulse: assert property (dr_update_stb_out |=> !dr_update_stb_out)
    else $error("strobe too long");
  chk_oe_idle: assert property ((tap_state_out == `JTP_ST_IDLE) [*3] |-> tdo_oe_n_out)
    else $error("tdo driven in idle");
endmodule // jtp_chk
bind jtp_tap_pin_ctrl jtp_chk jtp_chk_i (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .tck_in(tck_in),
  .trst_in(trst_in),
  .first_debug_pin_in(first_debug_pin_in),
  .second_debug_pin_in(second_debug_pin_in),
  .tdo_out(tdo_out),
  .tdo_oe_n_out(tdo_oe_n_out),
  .scan_control_out(scan_control_out),
  .boundary_scan_out(boundary_scan_out),
  .boot_suspend_debug_hold_out(boot_suspend_debug_hold_out),
  .tap_state_out(tap_state_out),
  .dr_update_stb_out(dr_update_stb_out)
);

//--- jtp_probe_model.sv
// Probe model driving the test port pins
`timescale 1ns/1ps
module jtp_probe_model (
  input wire core_clk_in,
  input wire tdo_in,
  output reg tck_out,
  output reg tms_out,
  output reg tdi_out,
  output reg trst_out
);
  reg got_ff; // Tdo seen just before a rise
  initial begin
    tck_out = 0; // Stands still between frames
    tms_out = 1;
    tdi_out = 1;
    trst_out = 0;
  end
  // Test reset change, then time for the synchronisers
  task set_trst(input logic v);
    @(negedge core_clk_in);
    trst_out = v;
    repeat (8) @(negedge core_clk_in);
  endtask
  // One 800 ns tck period; tdo is read late in the low half
  task step(input logic ms, input logic di);
    @(negedge core_clk_in);
    tms_out = ms;
    tdi_out = di;
    repeat (3) @(negedge core_clk_in);
    got_ff = tdo_in;
    tck_out = 1;
    repeat (4) @(negedge core_clk_in);
    tck_out = 0;
  endtask
  // LSB first; mode select goes high on the last bit
  task shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = got_ff;
    end
  endtask
endmodule // jtp_probe_model

//--- jtp_tap_pin_ctrl_tb_top.sv
// Testbench for the test port pin control block
`timescale 1ns/1ps
`include "jtp_defs.vh"
module jtp_tap_pin_ctrl_tb_top;
  reg [31:0] cap_val = 32'h0000_0000; // Word offered at the capture port, set per test
  reg clk = 0;
  reg rst = 1;
  reg pin_a = 1; // Debug pins idle at their pull-ups
  reg pin_b = 1;
  int n_fail = 0;
  int comparisons = 0;
  int n_stb = 0; // Update strobes seen
  wire tck, tms, tdi, trst, tdo, oe_n, scan, bscan, hold, stb;
  wire [3:0] st, ir;
  wire [31:0] dru;
  wire tdo_pin = oe_n ? ~tdo : tdo; // Released line shows the inverse of the last bit
  jtp_tap_pin_ctrl jtp_tap_pin_ctrl_i (.core_clk_in(clk), .rst_in(rst), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .trst_in(trst), .first_debug_pin_in(pin_a),
    .second_debug_pin_in(pin_b), .dr_capture_in(cap_val), .tdo_out(tdo),
    .tdo_oe_n_out(oe_n), .scan_control_out(scan), .boundary_scan_out(bscan),
    .boot_suspend_debug_hold_out(hold), .tap_state_out(st), .ir_out(ir),
    .dr_update_out(dru), .dr_update_stb_out(stb));
  jtp_probe_model jtp_probe_model_i (.core_clk_in(clk), .tdo_in(tdo_pin), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi), .trst_out(trst));
  always #50 clk = ~clk;
  // Strobe counter, sampled away from the launching edge
  always @(negedge clk) begin
    if (stb === 1'b1) n_stb = n_stb + 1;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // IR scan then a full 32-bit DR scan
  task t_tap;
    logic [31:0] o;
    cap_val = 32'hA5C3_0F96;
    jtp_probe_model_i.set_trst(1);
    check({31'h0, scan}, 1);
    jtp_probe_model_i.step(0, 1);
    check({28'h0, st}, `JTP_ST_IDLE);
    jtp_probe_model_i.step(1, 1);
    jtp_probe_model_i.step(1, 1);
    jtp_probe_model_i.step(0, 1);
    jtp_probe_model_i.step(0, 1);
    jtp_probe_model_i.shift(4, 32'h0000_0002, o);
    check(o, 32'h0000_0001);
    jtp_probe_model_i.step(1, 1);
    jtp_probe_model_i.step(1, 1);
    jtp_probe_model_i.step(0, 1);
    jtp_probe_model_i.step(0, 1);
    jtp_probe_model_i.shift(32, 32'h3C5A_96E1, o);
    check(o, cap_val);
    jtp_probe_model_i.step(1, 1);
    check({28'h0, st}, `JTP_ST_UPD_DR);
    jtp_probe_model_i.step(0, 1);
    repeat (5) @(negedge clk);
    check(dru, 32'h3C5A_96E1);
    check({28'h0, ir}, 32'h0000_0002);
    check(n_stb, 1);
    check({28'h0, st}, `JTP_ST_IDLE);
    jtp_probe_model_i.set_trst(0);
    check({28'h0, st}, `JTP_ST_RESET);
    $display("t_tap done");
  endtask
  // Reset instruction selects bypass: one-bit path that captures zero
  task t_bypass;
    logic [31:0] o;
    cap_val = 32'hFFFF_FFFF;
    jtp_probe_model_i.set_trst(1);
    check({28'h0, ir}, `JTP_IR_BYPASS);
    jtp_probe_model_i.step(0, 1);
    jtp_probe_model_i.step(1, 1);
    jtp_probe_model_i.step(0, 1);
    jtp_probe_model_i.step(0, 1);
    jtp_probe_model_i.shift(8, 32'h0000_00B5, o);
    check(o, 32'h0000_006A);
    jtp_probe_model_i.step(1, 1);
    jtp_probe_model_i.step(0, 1);
    check(n_stb, 2);
    check({31'h0, oe_n}, 1);
    jtp_probe_model_i.set_trst(0);
    $display("t_bypass done");
  endtask
  // Debug pin modes latched at test reset edges
  task t_mode;
    @(negedge clk);
    pin_a = 1;
    pin_b = 0;
    jtp_probe_model_i.set_trst(1);
    check({31'h0, bscan}, 1);
    jtp_probe_model_i.set_trst(0);
    pin_a = 0;
    pin_b = 1;
    jtp_probe_model_i.set_trst(1);
    jtp_probe_model_i.set_trst(0);
    check({31'h0, hold}, 1);
    check({31'h0, scan}, 0);
    $display("t_mode done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    t_tap;
    t_bypass;
    t_mode;
    report_and_stop;
  end
  initial begin
    #500_000;
    n_fail++;
    report_and_stop;
  end
endmodule // jtp_tap_pin_ctrl_tb_top
